//--- hw/lds_pkg.sv
// package for the led digit scan sequencer: constants, states, carriers
// assumes a single 250 MHz core clock domain
package lds_pkg;
   // clock and settle timing
   localparam int unsigned CORE_CLK_MHZ     = 250;
   localparam int unsigned SETTLE_TIME_US   = 1;
   localparam int unsigned SETTLE_CYCLES    = SETTLE_TIME_US * CORE_CLK_MHZ;

   // widths
   localparam int unsigned PORT_W = 8;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned CNT_W  = 16;

   // constants and reset values
   localparam logic [7:0]  BLANK_VALUE      = 8'hff;
   localparam logic [15:0] FIRST_DIGIT_RST  = 16'hfff7;
   localparam logic [15:0] LAST_DIGIT_RST   = 16'h0fff;
   localparam logic [15:0] PTR_RST          = 16'h0000;

   // register offsets
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_TABLE_BASE = 4'h1;
   localparam logic [3:0] REG_READ_PTR   = 4'h2;
   localparam logic [3:0] REG_DIGIT_SEL  = 4'h3;
   localparam logic [3:0] REG_FIRST_DIG  = 4'h4;
   localparam logic [3:0] REG_LAST_DIG   = 4'h5;
   localparam logic [3:0] REG_SETTLE     = 4'h6;
   localparam logic [3:0] REG_STATUS     = 4'h7;

   // ctrl / status bit positions
   localparam int unsigned CTRL_START_BIT  = 0;
   localparam int unsigned STAT_BUSY_BIT   = 0;
   localparam int unsigned STAT_HALT_BIT   = 1;
   localparam int unsigned STAT_RUN_BIT    = 2;

   typedef enum logic [2:0] {
      ST_HALT,
      ST_BLANK,
      ST_WAIT_COM,
      ST_FETCH,
      ST_WAIT_SEG,
      ST_ENABLE,
      ST_UPDATE,
      ST_FINISH
   } lds_state_e;

   // register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } lds_req_s;

   // memory read request
   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } lds_mem_req_s;
endpackage

//--- hw/lds_sync.sv
// two-flop synchroniser for a level coming from another domain
// assumes the input is asynchronous to i_core_clk
`timescale 1ns/1ps
module lds_sync
   import lds_pkg::*;
(
   // clock and control
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_ce,
   // level
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta_r;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         meta_r <= 1'b0;
         o_sync <= 1'b0;
      end else if (i_ce) begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

//--- hw/lds_timer.sv
// settle wait counter: pulses o_done i_len cycles after i_start (two cycles when i_len is 1)
// assumes i_len of at least one
`timescale 1ns/1ps
module lds_timer
   import lds_pkg::*;
#(
   parameter int unsigned W = CNT_W
)
(
   // clock and control
   input  wire logic         i_core_clk,
   input  wire logic         i_reset,
   input  wire logic         i_ce,
   // request
   input  wire logic         i_start,
   input  wire logic [W-1:0] i_len,
   // answer
   output logic              o_done
);
   logic [W-1:0] cnt_r;
   logic         run_r;

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         cnt_r  <= '0;
         run_r  <= 1'b0;
         o_done <= 1'b0;
      end else if (i_ce) begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_r <= i_len - W'(1);
            run_r <= 1'b1;
         end else if (run_r) begin
            if (cnt_r <= W'(1)) begin
               run_r  <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end
endmodule

//--- hw/lds_seq.sv
// led digit scan sequencer: one digit per interval-timer event
// assumes a byte memory with one-cycle read latency and an asynchronous trigger pin
// Contract
// - interval trigger event alone starts a pass; the code also needs the ctrl start bit set
// - pass starts by driving digit port ff
// - wait one microsecond after blanking
// - segment port takes table byte unchanged
// - wait one microsecond after segment drive
// - settle wait lengthens for external drivers
// - digit port takes digit select variable
// - read pointer advances by one
// - digit select shifts right one bit
// - compare shifted select with last digit
// - on last digit reload pointer base
// - on last digit reload first digit
// - pass ends halted without return code
`timescale 1ns/1ps
module lds_seq
   import lds_pkg::*;
(
   // clock, reset, enable
   input  wire logic               i_core_clk,
   input  wire logic               i_reset,
   input  wire logic               i_ce,
   // trigger pin
   input  wire logic               i_interval_trigger_event,
   // register port
   input  wire logic [3:0]         i_reg_addr,
   input  wire logic [WORD_W-1:0]  i_reg_wdata,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   output logic      [WORD_W-1:0]  o_reg_rdata,
   // table memory
   output logic                    o_mem_rd,
   output logic      [WORD_W-1:0]  o_mem_addr,
   input  wire logic [PORT_W-1:0]  i_mem_rdata,
   // display pins
   output logic      [PORT_W-1:0]  o_segment_port,
   output logic      [PORT_W-1:0]  o_digit_select_port,
   // status
   output logic                    o_halted
);
   lds_state_e        state_r;
   logic              run_r;
   logic [WORD_W-1:0] table_base_addr_r;
   logic [WORD_W-1:0] read_ptr_r;
   logic [WORD_W-1:0] digit_sel_r;
   logic [WORD_W-1:0] first_digit_r;
   logic [WORD_W-1:0] last_digit_r;
   logic [CNT_W-1:0]  settle_len_r;
   logic              trig_s;
   logic              trig_d_r;
   logic              trig_evt;
   logic              tmr_start;
   logic              tmr_done;
   logic              last_hit;
   logic [WORD_W-1:0] sel_shift;
   logic              sw_wr_ptr;
   logic              sw_wr_sel;
   lds_req_s          req;
   logic [WORD_W-1:0] rdata_nxt;

   assign req = '{addr: i_reg_addr, wdata: i_reg_wdata,
                  wr: i_reg_wr, rd: i_reg_rd};

   // trigger pin crosses into the core clock
   lds_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_ce       (i_ce),
      .i_async    (i_interval_trigger_event),
      .o_sync     (trig_s)
   );

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         trig_d_r <= 1'b0;
      end else if (i_ce) begin
         trig_d_r <= trig_s;
      end
   end

   // rising edge only; a level held high still starts a single pass
   assign trig_evt = trig_s & ~trig_d_r;

   lds_timer #(.W(CNT_W)) u_timer (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_ce       (i_ce),
      .i_start    (tmr_start),
      .i_len      (settle_len_r),
      .o_done     (tmr_done)
   );

   assign tmr_start = (state_r == ST_BLANK) || (state_r == ST_FETCH);
   assign sel_shift = digit_sel_r >> 1;
   assign last_hit  = (sel_shift == last_digit_r);

   // register writes that touch sequencer variables
   assign sw_wr_ptr = req.wr && (req.addr == REG_READ_PTR);
   assign sw_wr_sel = req.wr && (req.addr == REG_DIGIT_SEL);

   // pass state machine
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_r <= ST_HALT;
      end else if (i_ce) begin
         case (state_r)
            ST_HALT: begin
               if (run_r && trig_evt) begin
                  state_r <= ST_BLANK;
               end
            end
            ST_BLANK:    state_r <= ST_WAIT_COM;
            ST_WAIT_COM: begin
               if (tmr_done) begin
                  state_r <= ST_FETCH;
               end
            end
            ST_FETCH:    state_r <= ST_WAIT_SEG;
            ST_WAIT_SEG: begin
               if (tmr_done) begin
                  state_r <= ST_ENABLE;
               end
            end
            ST_ENABLE:   state_r <= ST_UPDATE;
            ST_UPDATE:   state_r <= ST_FINISH;
            ST_FINISH:   state_r <= ST_HALT;
            default:     state_r <= ST_HALT;
         endcase
      end
   end

   // software controls: start bit, base, first/last, settle length
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         run_r             <= 1'b0;
         table_base_addr_r <= PTR_RST;
         first_digit_r     <= FIRST_DIGIT_RST;
         last_digit_r      <= LAST_DIGIT_RST;
         settle_len_r      <= CNT_W'(SETTLE_CYCLES);
      end else if (i_ce && req.wr) begin
         case (req.addr)
            REG_CTRL:       run_r <= req.wdata[CTRL_START_BIT];
            REG_TABLE_BASE: table_base_addr_r <= req.wdata;
            REG_FIRST_DIG:  first_digit_r <= req.wdata;
            REG_LAST_DIG:   last_digit_r <= req.wdata;
            // longer settle for an external driver stage
            REG_SETTLE: begin
               if (req.wdata != '0) begin
                  settle_len_r <= req.wdata;
               end
            end
            default: ;
         endcase
      end
   end

   // read pointer; the sequencer wins over a software write in update
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         read_ptr_r <= PTR_RST;
      end else if (i_ce) begin
         if (state_r == ST_UPDATE) begin
            if (last_hit) begin
               read_ptr_r <= table_base_addr_r;
            end else begin
               read_ptr_r <= read_ptr_r + WORD_W'(1);
            end
         end else if (sw_wr_ptr) begin
            read_ptr_r <= req.wdata;
         end
      end
   end

   // digit select variable
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         digit_sel_r <= FIRST_DIGIT_RST;
      end else if (i_ce) begin
         if (state_r == ST_UPDATE) begin
            if (last_hit) begin
               digit_sel_r <= first_digit_r;
            end else begin
               digit_sel_r <= sel_shift;
            end
         end else if (sw_wr_sel) begin
            digit_sel_r <= req.wdata;
         end
      end
   end

   // memory fetch and display pins
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_mem_rd            <= 1'b0;
         o_mem_addr          <= PTR_RST;
         o_segment_port      <= '0;
         o_digit_select_port <= BLANK_VALUE;
      end else if (i_ce) begin
         o_mem_rd <= 1'b0;
         if (state_r == ST_HALT && run_r && trig_evt) begin
            o_digit_select_port <= BLANK_VALUE;
            o_mem_rd            <= 1'b1;
            o_mem_addr          <= read_ptr_r;
         end
         if (state_r == ST_FETCH) begin
            // memory answered one cycle after the request in blank
            o_segment_port <= i_mem_rdata;
         end
         if (state_r == ST_ENABLE) begin
            o_digit_select_port <= digit_sel_r[PORT_W-1:0];
         end
      end
   end

   // mem data is sampled in fetch; it must hold from the read until then
   always_comb begin
      rdata_nxt = '0;
      case (req.addr)
         REG_CTRL:       rdata_nxt[CTRL_START_BIT] = run_r;
         REG_TABLE_BASE: rdata_nxt = table_base_addr_r;
         REG_READ_PTR:   rdata_nxt = read_ptr_r;
         REG_DIGIT_SEL:  rdata_nxt = digit_sel_r;
         REG_FIRST_DIG:  rdata_nxt = first_digit_r;
         REG_LAST_DIG:   rdata_nxt = last_digit_r;
         REG_SETTLE:     rdata_nxt = settle_len_r;
         REG_STATUS: begin
            rdata_nxt[STAT_BUSY_BIT] = (state_r != ST_HALT);
            rdata_nxt[STAT_HALT_BIT] = (state_r == ST_HALT);
            rdata_nxt[STAT_RUN_BIT]  = run_r;
         end
         default:        rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_reg_rdata <= '0;
         o_halted    <= 1'b1;
      end else if (i_ce) begin
         o_reg_rdata <= req.rd ? rdata_nxt : '0;
         // drops on the start edge itself, so a starting pass never
         // shows halted while the blank is driven
         o_halted    <= ((state_r == ST_HALT) && !(run_r && trig_evt))
                        || (state_r == ST_FINISH);
      end
   end
endmodule

//--- bench/lds_table_model.sv
// segment table memory beside the scan sequencer
// assumes one read pulse per pass; byte stands until the next read
`timescale 1ns/1ps
module lds_table_model
   import lds_pkg::*;
(
   // clock
   input  wire logic              i_core_clk,
   // read request
   input  wire logic              i_mem_rd,
   input  wire logic [WORD_W-1:0] i_mem_addr,
   // answer and trace
   output logic      [PORT_W-1:0] o_mem_rdata,
   output logic      [WORD_W-1:0] o_last_addr
);
   initial o_mem_rdata = 8'h00;
   initial o_last_addr = 16'h0000;
   // byte derived from address so a wrong pointer shows at once
   always @(posedge i_core_clk) begin
      if (i_mem_rd) begin
         o_mem_rdata <= i_mem_addr[7:0] ^ 8'h5a;
         o_last_addr <= i_mem_addr;
      end
   end
endmodule

//--- bench/lds_seq_monitor.sv
// checker for the scan sequencer pins and register read port
// assumes the default settle count stays in force during passes
`timescale 1ns/1ps
module lds_seq_monitor
   import lds_pkg::*;
(
   // clock and reset
   input wire logic              i_core_clk,
   input wire logic              i_reset,
   // observed ports
   input wire logic              i_reg_rd,
   input wire logic [WORD_W-1:0] o_reg_rdata,
   input wire logic              o_mem_rd,
   input wire logic [PORT_W-1:0] o_segment_port,
   input wire logic [PORT_W-1:0] o_digit_select_port,
   input wire logic              o_halted
);
   logic [CNT_W-1:0] since_rd_r;
   // saturates so long idle spans never wrap
   always_ff @(posedge i_core_clk) begin
      if (i_reset || o_mem_rd)
         since_rd_r <= '0;
      else if (since_rd_r != '1)
         since_rd_r <= since_rd_r + 1'b1;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   a_blank_before_read: assert property (
      o_mem_rd |-> o_digit_select_port == BLANK_VALUE)
      else $error("digit port not blank at table read");
   a_segment_settled: assert property (
      !$stable(o_segment_port) |-> since_rd_r >= 16'd249)
      else $error("segment port changed too early");
   a_digit_settled: assert property (
      $changed(o_digit_select_port) && o_digit_select_port != BLANK_VALUE
      |-> since_rd_r >= 16'd499)
      else $error("digit enabled too early");
   a_one_digit_lit: assert property (
      $onehot0(~o_digit_select_port))
      else $error("more than one digit lit");
   a_single_read: assert property (
      o_mem_rd |=> !o_mem_rd)
      else $error("table read longer than one cycle");
   a_busy_in_pass: assert property (
      o_mem_rd |=> !o_halted [*8])
      else $error("halted during pass");
   a_rdata_idle: assert property (
      !i_reg_rd |=> o_reg_rdata == 16'h0000)
      else $error("read data without read");
   a_halt_holds: assert property (
      o_halted && $past(o_halted) |->
      $stable(o_digit_select_port) && $stable(o_segment_port))
      else $error("pins moved while halted");
   c_pass: cover property (o_mem_rd);
   c_last_digit: cover property (o_digit_select_port == 8'hfe);
   c_halt: cover property ($rose(o_halted));
endmodule
bind lds_seq lds_seq_monitor u_mon (
   .i_core_clk          (i_core_clk),
   .i_reset             (i_reset),
   .i_reg_rd            (i_reg_rd),
   .o_reg_rdata         (o_reg_rdata),
   .o_mem_rd            (o_mem_rd),
   .o_segment_port      (o_segment_port),
   .o_digit_select_port (o_digit_select_port),
   .o_halted            (o_halted)
);

//--- bench/lds_seq_bench.sv
// self-checking bench: register tasks, trigger passes, pin checks
// assumes the table model answers every read one cycle later
`timescale 1ns/1ps
module lds_seq_bench
   import lds_pkg::*;
;
   logic              i_core_clk = 1'b0;
   logic              i_reset    = 1'b1;
   logic              trig       = 1'b0;
   logic              ce         = 1'b1;
   lds_req_s          req        = '0;
   logic [WORD_W-1:0] rdata;
   logic [WORD_W-1:0] mem_addr;
   logic [WORD_W-1:0] last_addr;
   logic [PORT_W-1:0] mem_rdata;
   logic [PORT_W-1:0] seg;
   logic [PORT_W-1:0] dig;
   logic              mem_rd;
   logic              halted;
   int                n_fail      = 0;
   int                comparisons = 0;
   always #2 i_core_clk = ~i_core_clk;
   lds_seq u_dut (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(ce),
      .i_interval_trigger_event(trig), .i_reg_addr(req.addr),
      .i_reg_wdata(req.wdata), .i_reg_wr(req.wr), .i_reg_rd(req.rd),
      .o_reg_rdata(rdata), .o_mem_rd(mem_rd), .o_mem_addr(mem_addr),
      .i_mem_rdata(mem_rdata), .o_segment_port(seg),
      .o_digit_select_port(dig), .o_halted(halted));
   lds_table_model u_tbl (
      .i_core_clk(i_core_clk), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr),
      .o_mem_rdata(mem_rdata), .o_last_addr(last_addr));
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [WORD_W-1:0] seen,
                      input logic [WORD_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [WORD_W-1:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_core_clk);
      req.wr <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic chkr(input logic [3:0] a, input logic [WORD_W-1:0] exp,
                       input string nm);
      logic [WORD_W-1:0] d;
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_core_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
      chk(nm, d, exp);
      @(posedge i_core_clk);
   endtask
   // again: a second pin edge in mid-pass, which must be ignored
   task automatic pass(input bit again);
      int i;
      trig <= 1'b1;
      for (i = 0; i < 20 && halted !== 1'b0; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      @(posedge i_core_clk);
      trig <= 1'b0;
      if (again) begin
         repeat (50) @(posedge i_core_clk);
         trig <= 1'b1;
         repeat (8) @(posedge i_core_clk);
         trig <= 1'b0;
      end
      for (i = 0; i < 2000 && halted !== 1'b1; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      repeat (8) @(posedge i_core_clk);
   endtask
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      int n;
      logic [WORD_W-1:0] sel;
      logic [WORD_W-1:0] ptr;
      logic [WORD_W-1:0] shf;
      repeat (3) @(posedge i_core_clk);
      i_reset <= 1'b0;
      @(posedge i_core_clk);
      chk("digit_rst", {8'h00, dig}, 16'h00ff);
      chk("seg_rst", {8'h00, seg}, 16'h0000);
      chkr(REG_DIGIT_SEL, FIRST_DIGIT_RST, "sel_rst");
      chkr(REG_FIRST_DIG, FIRST_DIGIT_RST, "first_rst");
      chkr(REG_LAST_DIG, LAST_DIGIT_RST, "last_rst");
      chkr(REG_SETTLE, 16'(SETTLE_CYCLES), "settle_rst");
      chkr(REG_STATUS, 16'h0001 << STAT_HALT_BIT, "status_idle");
      wr(4'h8, 16'h1234);
      chkr(4'h8, 16'h0000, "unmapped");
      // run bit clear: pin edge alone does not start a pass
      pass(1'b0);
      chk("no_pass", {15'h0000, halted}, 16'h0001);
      chk("no_pass_dig", {8'h00, dig}, 16'h00ff);
      wr(REG_TABLE_BASE, 16'h0040);
      wr(REG_READ_PTR, 16'h0042);
      wr(REG_DIGIT_SEL, FIRST_DIGIT_RST);
      wr(REG_CTRL, 16'h0001);
      chkr(REG_STATUS, 16'h0006, "status_run");
      sel = FIRST_DIGIT_RST;
      ptr = 16'h0042;
      for (n = 0; n < 6; n++) begin
         pass(n == 1);
         chk("mem_addr", last_addr, ptr);
         chk("segment", {8'h00, seg}, {8'h00, ptr[7:0] ^ 8'h5a});
         chk("digit", {8'h00, dig}, {8'h00, sel[7:0]});
         shf = sel >> 1;
         if (shf == LAST_DIGIT_RST) begin
            ptr = 16'h0040;
            sel = FIRST_DIGIT_RST;
         end
         else begin
            ptr = ptr + 16'h0001;
            sel = shf;
         end
         chkr(REG_READ_PTR, ptr, "ptr");
         chkr(REG_DIGIT_SEL, sel, "sel");
      end
      // settle count is programmable; zero is refused
      wr(REG_SETTLE, 16'h000a);
      chkr(REG_SETTLE, 16'h000a, "settle_set");
      wr(REG_SETTLE, 16'h0000);
      chkr(REG_SETTLE, 16'h000a, "settle_zero");
      // clock enable low: a write in that cycle must be lost
      ce <= 1'b0;
      wr(REG_TABLE_BASE, 16'h0077);
      ce <= 1'b1;
      chkr(REG_TABLE_BASE, 16'h0040, "ce_frozen");
      tally_and_finish();
   end
endmodule
